// ===== dv/cct_timer_checker.sv
/*
  Bus timing checks for cct_timer, watching only its ports.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "cct_params.svh"

module cct_timer_checker (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  // Write channels
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic [1:0]             bresp,
  // Read channels
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic                   rvalid,
  input wire logic                   rready,
  input wire logic [31:0]            rdata,
  input wire logic [1:0]             rresp,
  // Channel pins
  input wire logic [`CCT_NUM_CH-1:0] compareOut
);
  // ----------------------------------------
  // Register bus timing
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  AST_WR_LATENCY: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer not two edges after handshake");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write response not retired");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_RD_LATENCY: assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one edge after handshake");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read answer changed before taken");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer not retired");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  AST_ERR_ZERO: assert property (rvalid && rresp == `CCT_RESP_SLV |-> rdata == 32'h0000_0000)
    else $error("error read returned data");

  // Main scenarios seen
  cover property (bvalid && bresp == `CCT_RESP_SLV);
  cover property (rvalid && rready);
  cover property ($changed(compareOut));
endmodule

bind cct_timer cct_timer_checker u_cct_timer_checker (
  .sys_clk(sys_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .compareOut(compareOut)
);

// ===== dv/cct_timer_tb_top.sv
/*
  Self-checking bench for cct_timer: bus tasks, one task per scenario.
  Assumes byte address = register index * 4 and the note's bus timing.
*/
`timescale 1ns/10ps
`include "cct_params.svh"

module cct_timer_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, freezeMode, waitMode;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, captureIn, compareOut;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp, lastResp;
  int          errorCnt, numChecks;

  // Clock of 100 ns
  always #50 sys_clk = ~sys_clk;

  cct_timer u_cct_timer (
    .sys_clk(sys_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .freezeMode(freezeMode),
    .waitMode(waitMode), .captureIn(captureIn), .compareOut(compareOut)
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [5:0] i, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= {i, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    // Response ready left high between transfers
    lastResp = bresp;
    chk({15'h0000, bvalid}, 16'h0001);
  endtask

  task automatic axr(input logic [5:0] i, output logic [7:0] d);
    int n;
    n = 0;
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rdata[7:0];
    lastResp = rresp;
    chk({15'h0000, rvalid}, 16'h0001);
  endtask

  task automatic rd16(input logic [5:0] i, output logic [15:0] v);
    logic [7:0] h, l;
    axr(i, h);
    axr(i + 6'h01, l);
    v = {h, l};
  endtask

  task automatic wr16(input logic [5:0] i, input logic [15:0] v);
    axw(i, v[15:8]);
    axw(i + 6'h01, v[7:0]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regmap;
    logic [15:0] v;
    logic [7:0]  b;
    for (int n = 0; n < 4; n++) begin
      rd16(`CCT_IDX_VALLO + 6'(2 * n), v);
      chk(v, `CCT_VAL_RST);
    end
    axw(`CCT_IDX_TOV, 8'hFF);
    axr(`CCT_IDX_TOV, b);
    chk({8'h00, b}, 16'h000F);
    wr16(6'h18, 16'hBEEF);
    rd16(6'h18, v);
    chk(v, 16'h0000);
    chk({14'h0000, lastResp}, {14'h0000, `CCT_RESP_OKAY});
    axr(6'h02, b);
    chk({6'h00, lastResp, b}, {6'h00, `CCT_RESP_SLV, 8'h00});
    axw(6'h03, 8'h55);
    chk({14'h0000, lastResp}, {14'h0000, `CCT_RESP_SLV});
    axr(`CCT_IDX_ACT1, b);
    chk({6'h00, lastResp, b}, {6'h00, `CCT_RESP_OKAY, 8'h00});
  endtask

  task automatic t_value;
    logic [15:0] v;
    logic [7:0]  b;
    logic [3:0]  p;
    axw(`CCT_IDX_MODE, 8'h02);
    wr16(`CCT_IDX_VALLO, 16'hABCD);
    wr16(`CCT_IDX_VALLO + 6'h02, 16'h8000);
    rd16(`CCT_IDX_VALLO, v);
    chk(v, 16'h0000);
    rd16(`CCT_IDX_VALLO + 6'h02, v);
    chk(v, 16'h8000);
    // Force strobe toggles compare channels only
    p = compareOut;
    axw(`CCT_IDX_FORCE, 8'h03);
    chk({12'h000, compareOut}, {12'h000, p ^ 4'h2});
    axr(`CCT_IDX_FORCE, b);
    chk({8'h00, b}, 16'h0000);
  endtask

  task automatic t_capture;
    logic [15:0] v;
    logic [7:0]  b;
    axw(`CCT_IDX_SYSC, 8'h00);
    wr16(`CCT_IDX_CNTH, 16'h1234);
    axw(`CCT_IDX_CHFLG, 8'h0F);
    captureIn <= 4'h1;
    repeat (3) @(posedge sys_clk);
    captureIn <= 4'h0;
    rd16(`CCT_IDX_VALLO, v);
    chk(v, 16'h1234);
    axr(`CCT_IDX_CHFLG, b);
    chk({8'h00, b}, 16'h0001);
    axw(`CCT_IDX_SYSC, 8'h18);
    axr(`CCT_IDX_SYSC, b);
    chk({8'h00, b}, 16'h0010);
    rd16(`CCT_IDX_VALLO, v);
    axr(`CCT_IDX_CHFLG, b);
    chk({8'h00, b}, 16'h0000);
  endtask

  task automatic t_wrap;
    logic [15:0] v;
    logic [7:0]  b;
    logic [3:0]  p;
    axw(`CCT_IDX_SYSC, 8'h00);
    wr16(`CCT_IDX_CNTH, 16'hFFF0);
    axw(`CCT_IDX_SYSC2, 8'h00);
    axw(`CCT_IDX_TOV, 8'h03);
    axw(`CCT_IDX_OVFLG, 8'h80);
    p = compareOut;
    axw(`CCT_IDX_SYSC, 8'h80);
    repeat (25) @(posedge sys_clk);
    axw(`CCT_IDX_SYSC, 8'h00);
    chk({12'h000, compareOut}, {12'h000, p ^ 4'h2});
    axr(`CCT_IDX_OVFLG, b);
    chk({8'h00, b}, 16'h0080);
    rd16(`CCT_IDX_CNTH, v);
    chk({15'h0000, v < 16'h0040}, 16'h0001);
    axr(`CCT_IDX_OVFLG, b);
    chk({8'h00, b}, 16'h0080);
    axw(`CCT_IDX_SYSC, 8'h10);
    axr(`CCT_IDX_CNTL, b);
    axr(`CCT_IDX_OVFLG, b);
    chk({8'h00, b}, 16'h0000);
  endtask

  task automatic t_freeze;
    logic [15:0] v;
    logic [15:0] w;
    wr16(`CCT_IDX_CNTH, 16'h0100);
    freezeMode <= 1'b1;
    axw(`CCT_IDX_SYSC, 8'hA0);
    repeat (20) @(posedge sys_clk);
    rd16(`CCT_IDX_CNTH, v);
    chk(v, 16'h0100);
    freezeMode <= 1'b0;
    repeat (20) @(posedge sys_clk);
    axw(`CCT_IDX_SYSC, 8'h00);
    rd16(`CCT_IDX_CNTH, v);
    chk({15'h0000, v > 16'h0100}, 16'h0001);
    // Stop bit clear: counter runs through freeze
    freezeMode <= 1'b1;
    axw(`CCT_IDX_SYSC, 8'h80);
    repeat (20) @(posedge sys_clk);
    axw(`CCT_IDX_SYSC, 8'h00);
    freezeMode <= 1'b0;
    rd16(`CCT_IDX_CNTH, w);
    chk({15'h0000, w > v}, 16'h0001);
  endtask

  // Ticks counted over 400 clocks must fall in lo..hi
  task automatic t_rate(input logic [7:0] s, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] v;
    axw(`CCT_IDX_SYSC, s);
    wr16(`CCT_IDX_CNTH, 16'h0000);
    axw(`CCT_IDX_SYSC, s | 8'h80);
    repeat (400) @(posedge sys_clk);
    axw(`CCT_IDX_SYSC, s);
    rd16(`CCT_IDX_CNTH, v);
    chk({15'h0000, v >= lo && v <= hi}, 16'h0001);
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic results;
    $display("Checks %0d, errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    results();
  end

  initial begin
    logic [7:0] b;
    sys_clk = 1'b0; resetn = 1'b0; freezeMode = 1'b0; waitMode = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h1;
    awprot = 3'h0; arprot = 3'h0; captureIn = 4'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regmap();
    t_value();
    t_capture();
    t_wrap();
    t_freeze();
    axw(`CCT_IDX_SYSC2, 8'h02);
    t_rate(8'h00, 16'h0062, 16'h0068);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    axw(`CCT_IDX_PREC, 8'h09);
    t_rate(8'h08, 16'h0026, 16'h002B);
    axr(`CCT_IDX_SYSC, b);
    chk({8'h00, b}, 16'h0008);
    results();
  end
endmodule

// ===== hdl/cct_params.svh
/*
  Register indexes, field positions, reset values and bus codes
  of the four-channel capture/compare timer.
  Assumes byte address = index * 4 on a 32-bit bus.
*/
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CCT_NUM_CH     4
`define CCT_IDX_W      6
`define CCT_ADDR_W     8
`define CCT_ADDR_LSB   2

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define CCT_IDX_MODE   6'h00
`define CCT_IDX_FORCE  6'h01
`define CCT_IDX_CNTH   6'h04
`define CCT_IDX_CNTL   6'h05
`define CCT_IDX_SYSC   6'h06
`define CCT_IDX_TOV    6'h07
`define CCT_IDX_ACT1   6'h08
`define CCT_IDX_SYSC2  6'h0D
`define CCT_IDX_CHFLG  6'h0E
`define CCT_IDX_OVFLG  6'h0F
`define CCT_IDX_VALLO  6'h10
`define CCT_IDX_VALHI  6'h1F
`define CCT_IDX_PREC   6'h20

// ----------------------------------------
// Fields, resets, responses
// ----------------------------------------
`define CCT_SYSC_RUN   7
`define CCT_SYSC_WAIT  6
`define CCT_SYSC_FRZ   5
`define CCT_SYSC_FAST  4
`define CCT_SYSC_PREC  3
`define CCT_OVF_BIT    7
`define CCT_CNT_RST    16'h0000
`define CCT_VAL_RST    16'h0000
`define CCT_BYTE_RST   8'h00
`define CCT_CNT_TOP    16'hFFFF
`define CCT_RESP_OKAY  2'h0
`define CCT_RESP_SLV   2'h2

`endif

// ===== hdl/cct_pkg.sv
/*
  Types of the capture/compare timer: state records of the
  register block and of the prescaler.
  Assumes cct_params.svh is on the include path.
*/
`include "cct_params.svh"

package cct_pkg;

  // ----------------------------------------
  // Register block state
  // ----------------------------------------
  typedef struct packed {
    logic                                awHeld;
    logic [`CCT_IDX_W-1:0]               awIdx;
    logic                                awReady;
    logic                                wHeld;
    logic [7:0]                          wData;
    logic                                wLane;
    logic                                wReady;
    logic                                bValid;
    logic [1:0]                          bResp;
    logic                                arReady;
    logic                                rValid;
    logic [1:0]                          rResp;
    logic [7:0]                          rData;
    logic [`CCT_NUM_CH-1:0]              modeSel;
    logic                                runEn;
    logic                                waitStop;
    logic                                frzStop;
    logic                                fastClr;
    logic                                precSel;
    logic                                precLocked;
    logic [2:0]                          legacyPre;
    logic [7:0]                          precPre;
    logic [`CCT_NUM_CH-1:0]              tov;
    logic [15:0]                         count;
    logic [`CCT_NUM_CH-1:0]              chFlag;
    logic                                wrapFlag;
    logic [`CCT_NUM_CH-1:0][15:0]        val;
    logic [`CCT_NUM_CH-1:0]              ocPin;
    logic [`CCT_NUM_CH-1:0]              capPrev;
    logic [7:0]                          rdLowBuf;
    logic [7:0]                          wrHighBuf;
  } cct_state_t;

  // ----------------------------------------
  // Prescaler state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } cct_pre_t;

endpackage

// ===== hdl/cct_prescaler.sv
/*
  Counter prescaler: one-cycle tick every 2**legacyPre clocks,
  or every precPre+1 clocks in precision mode.
  Assumes settings held steady by the register block.
*/
`timescale 1ns/10ps
`include "cct_params.svh"

module cct_prescaler
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Settings and tick
  cct_tick_if.pre   tickIf
);

  cct_pre_t   s;
  cct_pre_t   next_s;
  logic [7:0] limit;

  // Divide ratio minus one
  always_comb begin
    if (tickIf.precSel) begin
      limit = tickIf.precPre;
    end else begin
      limit = 8'((9'h001 << tickIf.legacyPre) - 9'h001);
    end
  end

  // Divider count and tick
  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!tickIf.run) begin
      next_s.cnt = `CCT_BYTE_RST;
    end else if (s.cnt >= limit) begin
      next_s.cnt  = `CCT_BYTE_RST;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tickIf.tick = s.tick;

endmodule

// ===== hdl/cct_tick_if.sv
/*
  Link between the register block and its prescaler.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps

interface cct_tick_if;
  logic       run;
  logic       precSel;
  logic [2:0] legacyPre;
  logic [7:0] precPre;
  logic       tick;

  modport ctrl (output run, output precSel, output legacyPre, output precPre, input tick);
  modport pre  (input run, input precSel, input legacyPre, input precPre, output tick);
endinterface

// ===== hdl/cct_timer.sv
/*
  Four-channel 16-bit capture/compare timer with an AXI4-Lite
  register slave, byte-wide registers at index*4.
  Assumes capture inputs and mode pins synchronous to sys_clk.
*/
`timescale 1ns/10ps
`include "cct_params.svh"

module cct_timer
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // AXI4-Lite write address
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`CCT_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  // AXI4-Lite write data and response
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`CCT_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Processor modes
  input  wire logic                   freezeMode,
  input  wire logic                   waitMode,
  // Channel pins
  input  wire logic [`CCT_NUM_CH-1:0] captureIn,
  output logic [`CCT_NUM_CH-1:0]      compareOut
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cct_state_t             s;
  cct_state_t             next_s;
  cct_tick_if             tickIf ();
  logic                   halted;
  logic                   adv;
  logic                   wrapNow;
  logic [15:0]            cntInc;
  logic                   wrDo;
  logic [`CCT_IDX_W-1:0]  rdIdx;
  logic [1:0]             rdCh;
  logic [1:0]             wrCh;
  logic                   rdErr;
  logic                   wrErr;
  logic [7:0]             rdByte;
  logic                   cntWr;
  logic [15:0]            cntWrVal;
  logic                   clrWrap;
  logic [`CCT_NUM_CH-1:0] clrCh;
  logic [`CCT_NUM_CH-1:0] forceReq;
  logic [`CCT_NUM_CH-1:0] capEdge;
  logic [`CCT_NUM_CH-1:0] cmpHit;
  logic [`CCT_NUM_CH-1:0] ovfTog;
  logic [`CCT_NUM_CH-1:0] pinTog;

  // ----------------------------------------
  // Counter advance
  // ----------------------------------------
  // Halt conditions, counter only
  // freeze or wait halt
  assign halted  = (s.frzStop && freezeMode) || (s.waitStop && waitMode);
  assign adv     = s.runEn && !halted && tickIf.tick && !cntWr;
  assign cntInc  = s.count + 16'h0001;
  assign wrapNow = adv && (s.count == `CCT_CNT_TOP);

  // Prescaler settings
  assign tickIf.run       = s.runEn && !halted;
  assign tickIf.precSel   = s.precSel;
  assign tickIf.legacyPre = s.legacyPre;
  assign tickIf.precPre   = s.precPre;

  cct_prescaler u_pre (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tickIf  (tickIf.pre)
  );

  // ----------------------------------------
  // Per-channel events
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CCT_NUM_CH; g++) begin : gen_ch
      assign capEdge[g] = !s.modeSel[g] && captureIn[g] && !s.capPrev[g];
      assign cmpHit[g]  = s.modeSel[g] && adv && (cntInc == s.val[g]);
      assign ovfTog[g]  = s.modeSel[g] && s.tov[g] && wrapNow;
      assign pinTog[g]  = ovfTog[g] || (s.modeSel[g] && (forceReq[g] || cmpHit[g]));
    end
  endgenerate

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // fixed offsets
  function automatic logic idxMapped(input logic [`CCT_IDX_W-1:0] idx);
    logic ok;
    ok = (idx == `CCT_IDX_MODE)  || (idx == `CCT_IDX_FORCE) ||
         (idx == `CCT_IDX_CNTH)  || (idx == `CCT_IDX_CNTL)  ||
         (idx == `CCT_IDX_SYSC)  || (idx == `CCT_IDX_TOV)   ||
         (idx == `CCT_IDX_ACT1)  || (idx == `CCT_IDX_SYSC2) ||
         (idx == `CCT_IDX_CHFLG) || (idx == `CCT_IDX_OVFLG) ||
         (idx == `CCT_IDX_PREC)  ||
         ((idx >= `CCT_IDX_VALLO) && (idx <= `CCT_IDX_VALHI));
    return ok;
  endfunction

  assign rdIdx = araddr[`CCT_ADDR_LSB+`CCT_IDX_W-1:`CCT_ADDR_LSB];
  assign rdCh  = rdIdx[2:1];
  assign wrCh  = s.awIdx[2:1];
  assign rdErr = !idxMapped(rdIdx);
  assign wrErr = !idxMapped(s.awIdx);
  assign wrDo  = s.awHeld && s.wHeld && !s.bValid;

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rdByte = `CCT_BYTE_RST;
    if (rdIdx == `CCT_IDX_MODE) begin
      rdByte = {4'h0, s.modeSel};
    end else if (rdIdx == `CCT_IDX_CNTH) begin
      rdByte = s.count[15:8];
    end else if (rdIdx == `CCT_IDX_CNTL) begin
      rdByte = s.rdLowBuf;
    end else if (rdIdx == `CCT_IDX_SYSC) begin
      rdByte = {s.runEn, s.waitStop, s.frzStop, s.fastClr, s.precSel, 3'h0};
    end else if (rdIdx == `CCT_IDX_TOV) begin
      rdByte = {4'h0, s.tov};
    end else if (rdIdx == `CCT_IDX_SYSC2) begin
      rdByte = {5'h00, s.legacyPre};
    end else if (rdIdx == `CCT_IDX_CHFLG) begin
      rdByte = {4'h0, s.chFlag};
    end else if (rdIdx == `CCT_IDX_OVFLG) begin
      rdByte = {s.wrapFlag, 7'h00};
    end else if (rdIdx == `CCT_IDX_PREC) begin
      rdByte = s.precPre;
    end else if ((rdIdx >= `CCT_IDX_VALLO) && (rdIdx <= `CCT_IDX_VALHI)) begin
      if (!rdIdx[3]) begin
        rdByte = rdIdx[0] ? s.rdLowBuf : s.val[rdCh][15:8];
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s   = s;
    cntWr    = 1'b0;
    cntWrVal = s.count;
    clrWrap  = 1'b0;
    clrCh    = '0;
    forceReq = '0;

    // Write address and data, either order
    if (awvalid && s.awReady) begin
      next_s.awHeld = 1'b1;
      next_s.awIdx  = awaddr[`CCT_ADDR_LSB+`CCT_IDX_W-1:`CCT_ADDR_LSB];
    end
    if (wvalid && s.wReady) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata[7:0];
      next_s.wLane = wstrb[0];
    end

    // Register write once both halves held
    if (wrDo) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = wrErr ? `CCT_RESP_SLV : `CCT_RESP_OKAY;
      if (s.wLane && !wrErr) begin
        if (s.awIdx == `CCT_IDX_MODE) begin
          next_s.modeSel = s.wData[3:0];
        end else if (s.awIdx == `CCT_IDX_FORCE) begin
          forceReq = s.wData[3:0];
        end else if (s.awIdx == `CCT_IDX_CNTH) begin
          next_s.wrHighBuf = s.wData;
          clrWrap = s.fastClr;
        end else if (s.awIdx == `CCT_IDX_CNTL) begin
          cntWr    = 1'b1;
          cntWrVal = {s.wrHighBuf, s.wData};
          clrWrap  = s.fastClr;
        end else if (s.awIdx == `CCT_IDX_SYSC) begin
          next_s.runEn    = s.wData[`CCT_SYSC_RUN];
          next_s.waitStop = s.wData[`CCT_SYSC_WAIT];
          next_s.frzStop  = s.wData[`CCT_SYSC_FRZ];
          next_s.fastClr  = s.wData[`CCT_SYSC_FAST];
          if (!s.precLocked) begin
            next_s.precSel    = s.wData[`CCT_SYSC_PREC];
            next_s.precLocked = 1'b1;
          end
        end else if (s.awIdx == `CCT_IDX_TOV) begin
          next_s.tov = s.wData[3:0];
        end else if (s.awIdx == `CCT_IDX_SYSC2) begin
          next_s.legacyPre = s.wData[2:0];
        end else if (s.awIdx == `CCT_IDX_CHFLG) begin
          clrCh = s.wData[3:0];
        end else if (s.awIdx == `CCT_IDX_OVFLG) begin
          clrWrap = s.wData[`CCT_OVF_BIT];
        end else if (s.awIdx == `CCT_IDX_PREC) begin
          next_s.precPre = s.wData;
        end else if ((s.awIdx >= `CCT_IDX_VALLO) && !s.awIdx[3]) begin
          if (s.modeSel[wrCh]) begin
            if (!s.awIdx[0]) begin
              next_s.wrHighBuf = s.wData;
            end else begin
              next_s.val[wrCh] = {s.wrHighBuf, s.wData};
            end
            clrCh[wrCh] = s.fastClr;
          end
        end
      end
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    next_s.awReady = !next_s.awHeld && !next_s.bValid;
    next_s.wReady  = !next_s.wHeld && !next_s.bValid;

    // Read access and its side effects
    if (arvalid && s.arReady) begin
      next_s.arReady = 1'b0;
      next_s.rValid  = 1'b1;
      next_s.rData   = rdByte;
      next_s.rResp   = rdErr ? `CCT_RESP_SLV : `CCT_RESP_OKAY;
      if (rdIdx == `CCT_IDX_CNTH) begin
        next_s.rdLowBuf = s.count[7:0];
        clrWrap         = clrWrap || s.fastClr;
      end else if (rdIdx == `CCT_IDX_CNTL) begin
        clrWrap = clrWrap || s.fastClr;
      end else if ((rdIdx >= `CCT_IDX_VALLO) && !rdErr && !rdIdx[3]) begin
        if (!rdIdx[0]) begin
          next_s.rdLowBuf = s.val[rdCh][7:0];
        end
        if (!s.modeSel[rdCh] && s.fastClr) begin
          clrCh[rdCh] = 1'b1;
        end
      end
    end
    if (s.rValid && rready) begin
      next_s.rValid  = 1'b0;
      next_s.arReady = 1'b1;
    end

    // Counter update and wrap
    // count and wrap
    if (cntWr) begin
      next_s.count = cntWrVal;
    end else if (adv) begin
      next_s.count = cntInc;
    end

    // Flags, set beats clear
    next_s.chFlag   = (s.chFlag & ~clrCh) | capEdge | cmpHit;
    next_s.wrapFlag = (s.wrapFlag && !clrWrap) || wrapNow;

    // Capture and pin actions
    for (int i = 0; i < `CCT_NUM_CH; i++) begin
      if (capEdge[i]) begin
        next_s.val[i] = s.count;
      end
    end
    next_s.ocPin   = s.ocPin ^ pinTog;
    next_s.capPrev = captureIn;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // values reset zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s         <= '0;
      s.awReady <= 1'b1;
      s.wReady  <= 1'b1;
      s.arReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready    = s.awReady;
  assign wready     = s.wReady;
  assign bvalid     = s.bValid;
  assign bresp      = s.bResp;
  assign arready    = s.arReady;
  assign rvalid     = s.rValid;
  assign rdata      = {24'h00_0000, s.rData};
  assign rresp      = s.rResp;
  assign compareOut = s.ocPin;

endmodule
